// file: rtl/hms_pkg.sv
// Purpose: Shared constants for the homing method sequencer.
// Assumes: 40 MHz clock, classic Wishbone with 32-bit data.
// Notes:   Byte offsets are word aligned; widths are fixed.
package hms_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00; // Method, direction, dog
	localparam logic [7:0] OFS_HOME_SPD  = 8'h04; // Homing speed
	localparam logic [7:0] OFS_CREEP_SPD = 8'h08; // Creep speed
	localparam logic [7:0] OFS_SHIFT     = 8'h0C; // Home shift distance
	localparam logic [7:0] OFS_HOME_POS  = 8'h10; // Home position data
	localparam logic [7:0] OFS_POST_DOG  = 8'h14; // Post-dog travel
	localparam logic [7:0] OFS_DWELL     = 8'h18; // Stopper dwell, ms
	localparam logic [7:0] OFS_STOP_TL   = 8'h1C; // Stopper torque limit
	localparam logic [7:0] OFS_INT_TL2   = 8'h20; // Internal limit two
	localparam logic [7:0] OFS_FWD_TL    = 8'h24; // Forward torque limit
	localparam logic [7:0] OFS_REV_TL    = 8'h28; // Reverse torque limit
	localparam logic [7:0] OFS_ACC_TC    = 8'h2C; // Entry 1 accel constant
	localparam logic [7:0] OFS_DEC_TC    = 8'h30; // Entry 1 decel constant
	localparam logic [7:0] OFS_STATUS    = 8'h34; // Live status, read only
	localparam logic [7:0] OFS_POSITION  = 8'h38; // Current position, RO
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h3C; // Sticky events, W1C
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h40; // Event enables

	// Control field positions
	localparam int CTRL_METHOD_LSB = 0;  // Four-bit method code
	localparam int CTRL_DIR_BIT    = 4;  // 1 = reverse direction
	localparam int CTRL_POL_BIT    = 5;  // 1 = dog active high

	// Method codes
	localparam logic [3:0] METHOD_STOPPER = 4'h3; // Stopper type
	localparam logic [3:0] METHOD_IGNORE  = 4'h4; // Servo-on as home
	localparam logic [3:0] METHOD_REAR    = 4'h5; // Dog rear-end reference

	// Interrupt bit positions
	localparam int IRQ_DONE_BIT  = 0;    // Homing completed
	localparam int IRQ_BAD_BIT   = 1;    // Request with unusable code
	localparam int IRQ_LIMIT_BIT = 2;    // Torque limiting began

	// Reset values
	localparam logic [5:0]  CTRL_RST  = 6'h23; // Stopper, dog active high
	localparam logic [15:0] SPD_RST   = 16'h0000; // Speeds
	localparam logic [31:0] DIST_RST  = 32'h0000_0000; // Distances
	localparam logic [15:0] TL_RST    = 16'hFFFF; // Torque limits
	localparam logic [15:0] TC_RST    = 16'h0001; // Ramp constants

	// Timing
	localparam int CLK_HZ        = 40_000_000; // Clock rate
	localparam int MS_TIME_US    = 1000;       // Dwell tick, us
	localparam int MS_CYCLES     = CLK_HZ / 1_000_000 * MS_TIME_US;
	localparam int STALL_TIME_US = 10;         // Stall hold, us
	localparam int STALL_CYCLES  = CLK_HZ / 1_000_000 * STALL_TIME_US;

	// Sequencer states, Gray along the dog path
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_FAST   = 3'b001,
		ST_CREEP  = 3'b011,
		ST_TRAVEL = 3'b010,
		ST_DONE   = 3'b110,
		ST_PRESS  = 3'b101,
		ST_DWELL  = 3'b100
	} hms_state_t;
endpackage

// file: rtl/hms_homing_sequencer.sv
// Purpose: Homing sequencer for a positioning servo, stopper, servo-on
//          and dog rear-end reference methods, behind a Wishbone slave.
// Assumes: Pins are asynchronous and synchronised here; torque feedback
//          comes from the current loop on the same clock.
// Notes:   Speed output is a ramped magnitude; dir_o gives the sense.

module hms_homing_sequencer #(
	parameter int TICK_CYCLES = hms_pkg::MS_CYCLES // Cycles per ms
) (
	input  wire logic        clk_i,                // 40 MHz clock
	input  wire logic        rst_i,                // Sync reset, high
	input  wire logic        wb_cyc_i,             // Bus cycle
	input  wire logic        wb_stb_i,             // Strobe
	input  wire logic        wb_we_i,              // Write enable
	input  wire logic [7:0]  wb_adr_i,             // Byte address
	input  wire logic [3:0]  wb_sel_i,             // Byte lanes
	input  wire logic [31:0] wb_dat_i,             // Write data
	output logic      [31:0] wb_dat_o,             // Read data
	output logic             wb_ack_o,             // Acknowledge
	input  wire logic        op_mode_select_one_i, // Mode pin
	input  wire logic [4:0]  table_select_i,       // Table pins 0..4
	input  wire logic        internal_limit_select_i, // Limit two pin
	input  wire logic        external_limit_select_i, // Analog sel pin
	input  wire logic [15:0] analog_torque_limit_i,   // Analog limit
	input  wire logic        dog_i,                // Proximity dog pin
	input  wire logic        servo_on_i,           // Servo-on pin
	input  wire logic        enc_pulse_i,          // Encoder step pin
	input  wire logic        enc_rev_i,            // Encoder sense pin
	input  wire logic [15:0] torque_fb_i,          // Torque magnitude
	output logic      [15:0] speed_cmd_o,          // Speed command
	output logic             dir_o,                // 1 = reverse
	output logic      [15:0] torque_limit_o,       // Active limit
	output logic             homing_complete_out_o, // Home reached
	output logic             torque_limiting_flag_o, // At a limit
	output logic             irq_o                 // Level interrupt
);
	// Configuration registers
	logic [5:0]  ctrl_q;                 // Method, direction, polarity
	logic [15:0] home_spd_q, creep_spd_q; // Homing and creep speeds
	logic [31:0] shift_q, post_dog_q;    // Shift, post-dog travel
	logic [31:0] home_pos_q;             // Home position data
	logic [15:0] dwell_q;                // Stopper dwell, ms
	logic [15:0] stop_tl_q, int_tl2_q;   // Stopper limit, limit two
	logic [15:0] fwd_tl_q, rev_tl_q;     // Forward, reverse limits
	logic [15:0] acc_tc_q, dec_tc_q;     // Cycles per ramp step
	logic [2:0]  irq_stat_q, irq_mask_q; // Sticky events, enables
	// Synchronisers, two stages, stage one read only by stage two
	logic [27:0] sync1_q;                // First stage
	logic [27:0] sync2_q;                // Second stage
	logic        enc_prev_q, son_prev_q, req_prev_q; // Edge memories
	// Sequencer
	hms_pkg::hms_state_t state_q;        // Sequencer state
	logic [31:0] pos_q;                  // Current position
	logic [31:0] travel_q;               // Steps since rear end
	logic [15:0] target_q;               // Speed the ramp aims at
	logic [15:0] ramp_cnt_q;             // Ramp step timer
	logic [31:0] tick_cnt_q;             // Ms prescaler
	logic [15:0] dwell_cnt_q, stall_cnt_q; // Dwell ms, stalled cycles
	logic        limit_prev_q;           // Limiting flag memory
	// Decoded inputs: seven single pins on top, table, analog limit
	logic        mode_s, son_s, dog_s, enc_s, rev_s, isel_s, esel_s;
	logic [4:0]  tsel_s;
	logic [15:0] tla_s;
	assign {mode_s, son_s, dog_s, enc_s, rev_s, isel_s, esel_s} =
		sync2_q[27:21];
	assign tsel_s = sync2_q[20:16];
	assign tla_s  = sync2_q[15:0];
	// Derived controls
	logic [3:0]  method;                 // Method code field
	logic        dog_act;                // Dog seen at its active level
	logic        enc_step, son_rise;     // Encoder step, servo-on edge
	logic        home_req;               // Rising homing request
	logic        wr_en;                  // Write takes effect now
	logic [15:0] other_tl, eff_tl;       // Pin-chosen, applied limits
	logic        at_limit, done_evt;     // Torque at limit, completion
	logic [31:0] dist_tot, wmask;        // Travel plus shift, lane mask
	assign method   = ctrl_q[hms_pkg::CTRL_METHOD_LSB +: 4];
	// Polarity bit chooses which level means dog present
	assign dog_act  = ctrl_q[hms_pkg::CTRL_POL_BIT] ? dog_s : !dog_s;
	assign enc_step = enc_s && !enc_prev_q;
	// Mode pin on with every table pin off is a homing request
	assign home_req = mode_s && (tsel_s == 5'h00) && !req_prev_q;
	assign son_rise = son_s && !son_prev_q;
	assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign dist_tot = post_dog_q + shift_q;
	assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign done_evt = ((state_q == hms_pkg::ST_TRAVEL) && enc_step &&
		(travel_q + 32'h0000_0001 >= dist_tot)) ||
		((state_q == hms_pkg::ST_DWELL) && (dwell_cnt_q >= dwell_q)) ||
		((method == hms_pkg::METHOD_IGNORE) && son_rise);
	// Analog limit when the external select is on, else limit two;
	// pressing takes the smaller of that and the stopper limit if either select is on
	always_comb begin
		other_tl = esel_s ? tla_s : int_tl2_q;
		eff_tl   = dir_o ? rev_tl_q : fwd_tl_q;
		if (state_q == hms_pkg::ST_PRESS) begin
			eff_tl = ((isel_s || esel_s) && other_tl < stop_tl_q) ?
				other_tl : stop_tl_q;
		end
	end
	// Reaching forward, reverse or a selected limit two
	assign at_limit = (torque_fb_i >= fwd_tl_q) ||
		(torque_fb_i >= rev_tl_q) ||
		(isel_s && torque_fb_i >= int_tl2_q);
	// Pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			{enc_prev_q, son_prev_q, req_prev_q} <= 3'h0;
		end else begin
			sync1_q    <= {op_mode_select_one_i, servo_on_i, dog_i,
				enc_pulse_i, enc_rev_i, internal_limit_select_i,
				external_limit_select_i, table_select_i,
				analog_torque_limit_i};
			sync2_q    <= sync1_q;
			enc_prev_q <= enc_s;
			son_prev_q <= son_s;
			req_prev_q <= mode_s && (tsel_s == 5'h00);
		end
	end
	// Wishbone ack, one cycle after the strobe, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			case (wb_adr_i)
				hms_pkg::OFS_CTRL:      wb_dat_o <= {26'h0, ctrl_q};
				hms_pkg::OFS_HOME_SPD:  wb_dat_o <= {16'h0, home_spd_q};
				hms_pkg::OFS_CREEP_SPD: wb_dat_o <= {16'h0, creep_spd_q};
				hms_pkg::OFS_SHIFT:     wb_dat_o <= shift_q;
				hms_pkg::OFS_HOME_POS:  wb_dat_o <= home_pos_q;
				hms_pkg::OFS_POST_DOG:  wb_dat_o <= post_dog_q;
				hms_pkg::OFS_DWELL:     wb_dat_o <= {16'h0, dwell_q};
				hms_pkg::OFS_STOP_TL:   wb_dat_o <= {16'h0, stop_tl_q};
				hms_pkg::OFS_INT_TL2:   wb_dat_o <= {16'h0, int_tl2_q};
				hms_pkg::OFS_FWD_TL:    wb_dat_o <= {16'h0, fwd_tl_q};
				hms_pkg::OFS_REV_TL:    wb_dat_o <= {16'h0, rev_tl_q};
				hms_pkg::OFS_ACC_TC:    wb_dat_o <= {16'h0, acc_tc_q};
				hms_pkg::OFS_DEC_TC:    wb_dat_o <= {16'h0, dec_tc_q};
				hms_pkg::OFS_STATUS:    wb_dat_o <= {26'h0, dog_act,
					torque_limiting_flag_o, homing_complete_out_o,
					state_q};
				hms_pkg::OFS_POSITION:  wb_dat_o <= pos_q;
				hms_pkg::OFS_IRQ_STAT:  wb_dat_o <= {29'h0, irq_stat_q};
				hms_pkg::OFS_IRQ_MASK:  wb_dat_o <= {29'h0, irq_mask_q};
				// Unmapped reads answer zero
				default:                wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Register writes at the acknowledging edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q      <= hms_pkg::CTRL_RST;
			home_spd_q  <= hms_pkg::SPD_RST;
			creep_spd_q <= hms_pkg::SPD_RST;
			shift_q     <= hms_pkg::DIST_RST;
			home_pos_q  <= hms_pkg::DIST_RST;
			post_dog_q  <= hms_pkg::DIST_RST;
			dwell_q     <= hms_pkg::SPD_RST;
			stop_tl_q   <= hms_pkg::TL_RST;
			int_tl2_q   <= hms_pkg::TL_RST;
			fwd_tl_q    <= hms_pkg::TL_RST;
			rev_tl_q    <= hms_pkg::TL_RST;
			acc_tc_q    <= hms_pkg::TC_RST;
			dec_tc_q    <= hms_pkg::TC_RST;
			irq_mask_q  <= 3'h0;
		end else if (wr_en) begin
			case (wb_adr_i)
				hms_pkg::OFS_CTRL:      ctrl_q <= (ctrl_q & ~wmask[5:0]) |
					(wb_dat_i[5:0] & wmask[5:0]);
				hms_pkg::OFS_HOME_SPD:  home_spd_q  <= wb_dat_i[15:0];
				hms_pkg::OFS_CREEP_SPD: creep_spd_q <= wb_dat_i[15:0];
				hms_pkg::OFS_SHIFT:     shift_q <= (shift_q & ~wmask) |
					(wb_dat_i & wmask);
				hms_pkg::OFS_HOME_POS:  home_pos_q <= (home_pos_q & ~wmask)
					| (wb_dat_i & wmask);
				hms_pkg::OFS_POST_DOG:  post_dog_q <= (post_dog_q & ~wmask)
					| (wb_dat_i & wmask);
				hms_pkg::OFS_DWELL:     dwell_q    <= wb_dat_i[15:0];
				hms_pkg::OFS_STOP_TL:   stop_tl_q  <= wb_dat_i[15:0];
				hms_pkg::OFS_INT_TL2:   int_tl2_q  <= wb_dat_i[15:0];
				hms_pkg::OFS_FWD_TL:    fwd_tl_q   <= wb_dat_i[15:0];
				hms_pkg::OFS_REV_TL:    rev_tl_q   <= wb_dat_i[15:0];
				hms_pkg::OFS_ACC_TC:    acc_tc_q   <= wb_dat_i[15:0];
				hms_pkg::OFS_DEC_TC:    dec_tc_q   <= wb_dat_i[15:0];
				hms_pkg::OFS_IRQ_MASK:  irq_mask_q <= wb_dat_i[2:0];
				// Read-only and unmapped writes are dropped
				default: ;
			endcase
		end
	end

	// Sequencer, targets and home capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q               <= hms_pkg::ST_IDLE;
			target_q              <= 16'h0000;
			travel_q              <= 32'h0000_0000;
			dwell_cnt_q           <= 16'h0000;
			homing_complete_out_o <= 1'b0;
			dir_o                 <= 1'b0;
		end else begin
			case (state_q)
				hms_pkg::ST_IDLE, hms_pkg::ST_DONE: begin
					target_q <= 16'h0000;
					if (home_req && (method == hms_pkg::METHOD_STOPPER ||
						method == hms_pkg::METHOD_REAR)) begin
						// Direction from the control field
						dir_o    <= ctrl_q[hms_pkg::CTRL_DIR_BIT];
						target_q <= home_spd_q;
						homing_complete_out_o <= 1'b0;
						state_q  <= (method == hms_pkg::METHOD_STOPPER) ?
							hms_pkg::ST_PRESS : hms_pkg::ST_FAST;
					end
				end
				hms_pkg::ST_FAST: begin
					// Front end seen: ramp down to creep
					if (dog_act) begin
						target_q <= creep_spd_q;
						state_q  <= hms_pkg::ST_CREEP;
					end
				end
				hms_pkg::ST_CREEP: begin
					// Rear end by sampled dog, no index pulse used
					if (!dog_act) begin
						travel_q <= 32'h0000_0000;
						state_q  <= hms_pkg::ST_TRAVEL;
					end
				end
				hms_pkg::ST_TRAVEL: begin
					if (done_evt) begin
						target_q <= 16'h0000;
						state_q  <= hms_pkg::ST_DONE;
					end else if (enc_step) begin
						travel_q <= travel_q + 32'h0000_0001;
					end
				end
				hms_pkg::ST_PRESS: begin
					// Stalled at the limit: contact taken, dwell begins
					if (stall_cnt_q >= 16'(hms_pkg::STALL_CYCLES)) begin
						target_q    <= 16'h0000;
						dwell_cnt_q <= 16'h0000;
						state_q     <= hms_pkg::ST_DWELL;
					end
				end
				hms_pkg::ST_DWELL: begin
					if (done_evt) begin
						state_q <= hms_pkg::ST_DONE;
					end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
						dwell_cnt_q <= dwell_cnt_q + 16'h0001;
					end
				end
				default: state_q <= hms_pkg::ST_IDLE;
			endcase
			// Completion on any done event; servo-on home whatever the mode pins say
			if (done_evt) begin
				homing_complete_out_o <= 1'b1;
			end
		end
	end

	// Position counter, reloaded with home data on completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_q <= 32'h0000_0000;
		end else if (done_evt) begin
			pos_q <= home_pos_q;
		end else if (enc_step) begin
			pos_q <= rev_s ? pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
		end
	end

	// Ramp toward the target with entry 1 constants
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			speed_cmd_o <= 16'h0000;
			ramp_cnt_q  <= 16'h0000;
		end else if (speed_cmd_o == target_q) begin
			ramp_cnt_q <= 16'h0000;
		end else if (ramp_cnt_q + 16'h0001 >= (speed_cmd_o < target_q ?
			acc_tc_q : dec_tc_q)) begin
			ramp_cnt_q  <= 16'h0000;
			speed_cmd_o <= (speed_cmd_o < target_q) ?
				speed_cmd_o + 16'h0001 : speed_cmd_o - 16'h0001;
		end else begin
			ramp_cnt_q <= ramp_cnt_q + 16'h0001;
		end
	end

	// Ms prescaler and stall timer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q  <= 32'h0000_0000;
			stall_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ?
				32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			// Any encoder step restarts the stall window
			if (state_q != hms_pkg::ST_PRESS || enc_step ||
				torque_fb_i < eff_tl) begin
				stall_cnt_q <= 16'h0000;
			end else if (stall_cnt_q < 16'(hms_pkg::STALL_CYCLES)) begin
				stall_cnt_q <= stall_cnt_q + 16'h0001;
			end
		end
	end

	// Limit output, flag and interrupts; set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			torque_limit_o         <= hms_pkg::TL_RST;
			torque_limiting_flag_o <= 1'b0;
			limit_prev_q           <= 1'b0;
			irq_stat_q             <= 3'h0;
			irq_o                  <= 1'b0;
		end else begin
			torque_limit_o         <= eff_tl;
			torque_limiting_flag_o <= at_limit;
			limit_prev_q           <= at_limit;
			irq_stat_q <= (irq_stat_q & ~((wr_en &&
				wb_adr_i == hms_pkg::OFS_IRQ_STAT) ? wb_dat_i[2:0] : 3'h0))
				| {at_limit && !limit_prev_q,
				home_req && method != hms_pkg::METHOD_STOPPER &&
				method != hms_pkg::METHOD_REAR, done_evt};
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Completion follows the dwell count in stopper homing
	dwell_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_DWELL && dwell_cnt_q >= dwell_q |=>
		homing_complete_out_o && state_q == hms_pkg::ST_DONE)
		else $error("dwell end without completion");
	// Completion loads home data into position
	home_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_evt |=> pos_q == $past(home_pos_q))
		else $error("home data not loaded");
	// Stopper limit applied while pressing
	stop_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_PRESS && !isel_s && !esel_s |=>
		torque_limit_o == $past(stop_tl_q))
		else $error("stopper limit not applied");
	// Never above the stopper limit while pressing
	stop_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_PRESS |=> torque_limit_o <= $past(stop_tl_q))
		else $error("limit above stopper value");
	// Flag follows torque at limit
	limit_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		torque_fb_i >= fwd_tl_q |=> torque_limiting_flag_o)
		else $error("limiting flag missed");
	// Stopper request starts pressing at homing speed
	stop_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_IDLE && home_req &&
		method == hms_pkg::METHOD_STOPPER |=>
		state_q == hms_pkg::ST_PRESS && target_q == $past(home_spd_q))
		else $error("stopper start wrong");
	// Dog front end switches to creep
	front_creep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_FAST && dog_act |=>
		state_q == hms_pkg::ST_CREEP && target_q == $past(creep_spd_q))
		else $error("creep not entered at dog");
	// Servo-on home completes at once
	son_home_a: assert property (@(posedge clk_i) disable iff (rst_i)
		method == hms_pkg::METHOD_IGNORE && son_rise |=>
		homing_complete_out_o)
		else $error("servo-on home missed");
	// Stall held long enough leaves pressing
	stall_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == hms_pkg::ST_PRESS &&
		stall_cnt_q >= 16'(hms_pkg::STALL_CYCLES) |=>
		state_q == hms_pkg::ST_DWELL && target_q == 16'h0000)
		else $error("stall not taken as contact");
endmodule

// file: testbench/hms_plant_model.sv
// Purpose: Motor, encoder, dog and stopper stand-in for the sequencer.
// Assumes: One encoder step every four cycles while asked to move.
// Notes:   Dog window is fixed at positions 20 to 39, active high.
module hms_plant_model (
	input  wire logic        clk_i,    // Clock
	input  wire logic [15:0] speed_i,  // Speed command
	input  wire logic        dir_i,    // 1 = reverse
	input  wire logic [15:0] limit_i,  // Granted torque limit
	input  wire logic        stop_i,   // Workpiece on the stopper
	output logic             pulse_o,  // Encoder step
	output logic             dog_o,    // Proximity dog
	output logic      [15:0] torque_o, // Torque magnitude
	output int               pos_o     // Shaft position
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ph_q = 2'h0; // Step phase
	initial pos_o = 0;
	// Steps only while commanded and free; a pressed shaft stalls
	always @(posedge clk_i) begin
		if (speed_i != 16'h0000 && !stop_i) begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h1) begin
				pos_o <= dir_i ? pos_o - 1 : pos_o + 1;
			end
		end
	end
	assign pulse_o = ph_q[1];
	// Sits on the granted limit when pressed, so stall reads as contact
	assign torque_o = stop_i ? limit_i : 16'h0010;
	assign dog_o = (pos_o >= 20 && pos_o < 40);
endmodule

// file: testbench/test_homing_method_sequencer.sv
// Purpose: Self-checking bench for the homing sequencer.
// Assumes: Short ms tick so the stopper dwell fits the run.
// Notes:   Pins driven here, motion comes from the plant model.
module test_homing_method_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic        mode = 0, isel = 0, esel = 0, svon = 0, stop = 0;
	logic [15:0] analog_torque_limit = 16'h0200;    // Analog limit level
	logic        ack, dir, done, flag, irq, pulse, dog;
	logic [4:0]  tsel = 5'h1F;      // Table pins, away from homing
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [15:0] spd, tlim, trq, lim_seen, fast_seen, creep_seen;
	int          pos, pos_done, err_count = 0, n_checks = 0, cyc_n = 0;
	always #12.5 clk_i = ~clk_i;
	hms_homing_sequencer #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .op_mode_select_one_i(mode), .table_select_i(tsel),
		.internal_limit_select_i(isel), .external_limit_select_i(esel),
		.analog_torque_limit_i(analog_torque_limit), .dog_i(dog), .servo_on_i(svon),
		.enc_pulse_i(pulse), .enc_rev_i(dir), .torque_fb_i(trq),
		.speed_cmd_o(spd), .dir_o(dir), .torque_limit_o(tlim),
		.homing_complete_out_o(done), .torque_limiting_flag_o(flag),
		.irq_o(irq));
	hms_plant_model plant_u (.clk_i(clk_i), .speed_i(spd), .dir_i(dir),
		.limit_i(tlim), .stop_i(stop), .pulse_o(pulse), .dog_o(dog),
		.torque_o(trq), .pos_o(pos));
	// Snapshots of speed, limit and plant position at dog edges, flag rise and completion
	always @(posedge dog) #1 fast_seen = spd;
	always @(negedge dog) #1 creep_seen = spd;
	always @(posedge flag) #1 lim_seen = tlim;
	always @(posedge done) #1 pos_done = pos;
	// Hang guard, well above the longest stall plus dwell
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Pulse the homing request and wait for a fresh completion
	task automatic request();
		mode <= 1'b1;
		tsel <= 5'h00;
		wait (done === 1'b0);
		repeat (2) @(posedge clk_i);
		stop <= isel;
		mode <= 1'b0;
		wait (done === 1'b1);
		// Let the ramp-down overshoot settle before reading back
		repeat (20) @(posedge clk_i);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, hms_pkg::OFS_CTRL, 0);
		chk("ctrl reset", q, 32'h23);
		bus(0, hms_pkg::OFS_STOP_TL, 0);
		chk("limit reset", q, 32'hFFFF);
		bus(0, 8'h44, 0);
		chk("unmapped read", q, 32'h0);
		// Servo-on home, mode pins left off
		bus(1, hms_pkg::OFS_HOME_POS, 32'h1234);
		bus(1, hms_pkg::OFS_CTRL, 32'h24);
		svon <= 1'b1;
		wait (done === 1'b1);
		bus(0, hms_pkg::OFS_POSITION, 0);
		chk("servo-on home", q, 32'h1234);
		chk("irq masked", irq, 0);
		bus(1, hms_pkg::OFS_IRQ_MASK, 1);
		bus(0, hms_pkg::OFS_IRQ_STAT, 0);
		chk("irq raised", irq, 1);
		bus(1, hms_pkg::OFS_IRQ_STAT, 1);
		bus(0, hms_pkg::OFS_IRQ_STAT, 0);
		chk("irq cleared", irq, 0);
		// Dog rear-end reference, forward, dog active high
		bus(1, hms_pkg::OFS_HOME_SPD, 32'h10);
		bus(1, hms_pkg::OFS_CREEP_SPD, 32'h4);
		bus(1, hms_pkg::OFS_POST_DOG, 32'h8);
		bus(1, hms_pkg::OFS_SHIFT, 32'h4);
		bus(1, hms_pkg::OFS_HOME_POS, 32'h5678);
		bus(1, hms_pkg::OFS_CTRL, 32'h25);
		request();
		chk("fast speed", fast_seen, 16'h10);
		chk("creep speed", creep_seen, 16'h4);
		chk("direction", dir, 0);
		chk("travel", pos_done >= 52 && pos_done <= 54, 1);
		bus(0, hms_pkg::OFS_POSITION, 0);
		chk("rear-end home", q, 32'h5678 + (pos - pos_done));
		// Stopper, reverse, limit two selected and below stopper limit
		bus(1, hms_pkg::OFS_INT_TL2, 32'h80);
		bus(1, hms_pkg::OFS_STOP_TL, 32'h100);
		bus(1, hms_pkg::OFS_DWELL, 32'h2);
		bus(1, hms_pkg::OFS_HOME_POS, 32'h9ABC);
		bus(1, hms_pkg::OFS_CTRL, 32'h33);
		isel <= 1'b1;
		request();
		chk("pressing limit", lim_seen, 16'h80);
		chk("direction", dir, 1);
		bus(0, hms_pkg::OFS_POSITION, 0);
		chk("stopper home", q, 32'h9ABC + (pos - pos_done));
		bus(0, hms_pkg::OFS_IRQ_STAT, 0);
		chk("events", q, 32'h5);
		// Stopper again: external select picks the analog limit
		analog_torque_limit <= 16'h00C0;
		esel <= 1'b1;
		stop <= 1'b0;
		request();
		chk("analog limit", lim_seen, 16'hC0);
		chk("analog done", done, 1);
		// Unusable code: refused, completion kept
		bus(1, hms_pkg::OFS_IRQ_STAT, 32'h7);
		bus(1, hms_pkg::OFS_CTRL, 32'h21);
		mode <= 1'b1;
		repeat (10) @(posedge clk_i);
		bus(0, hms_pkg::OFS_IRQ_STAT, 0);
		chk("bad code", q, 32'h2);
		chk("complete kept", done, 1);
		end_of_test();
	end
endmodule
